// ===== src/iwbc_pkg.sv
// Package: constants, types and helpers of the image window and binning control block
package iwbc_pkg;

  // Field widths
  localparam int ROW_W = 11;                            // Row pointer / depth width
  localparam int COL_W = 12;                            // Column pointer / width width
  localparam int EXP_W = 17;                            // Exposure width in microseconds
  localparam int GAIN_W = 7;                            // Gain percentage width
  localparam int PIX_W = 8;                             // Pixel intensity width

  // Sensor variants
  localparam logic [1:0] VAR_FIVE_MP = 2'h0;            // five_megapixel_variant
  localparam logic [1:0] VAR_MEGA = 2'h1;               // megapixel_variant
  localparam logic [1:0] VAR_WIDE_VGA_VARIANT = 2'h2;               // wide_vga_variant

  // Sensor geometry per variant
  localparam logic [ROW_W-1:0] ROWS_FIVE_MP = 11'd1944;
  localparam logic [ROW_W-1:0] ROWS_MEGA = 11'd960;
  localparam logic [ROW_W-1:0] ROWS_WIDE_VGA_VARIANT = 11'd480;
  localparam logic [COL_W-1:0] COLS_FIVE_MP = 12'd2592;
  localparam logic [COL_W-1:0] COLS_MEGA = 12'd1280;
  localparam logic [COL_W-1:0] COLS_WIDE_VGA_VARIANT = 12'd752;
  localparam int LB_DEPTH = 1296;                       // Half the widest row, for binning

  // Limits and reset values
  localparam logic [31:0] ROW_DEPTH_MIN = 32'h3;        // Fewest window rows
  localparam logic [31:0] COL_WIDTH_MIN = 32'h8;        // Fewest window columns
  localparam logic [31:0] EXP_MIN_US = 32'd50;          // Shortest exposure
  localparam logic [31:0] EXP_MAX_US = 32'd100000;      // Longest exposure
  localparam logic [EXP_W-1:0] EXP_RST_US = 17'd2500;   // Exposure after reset
  localparam logic [31:0] GAIN_MAX = 32'd100;           // Highest gain percentage
  localparam logic [GAIN_W-1:0] GAIN_RST_HI = 7'd33;    // Gain after reset, 5MP and WIDE_VGA_VARIANT
  localparam logic [GAIN_W-1:0] GAIN_RST_LO = 7'd0;     // Gain after reset, megapixel
  localparam logic [GAIN_W-1:0] GAIN_STEP = 7'd25;      // Span of one quantised level

  // Register byte offsets
  localparam logic [7:0] REG_ROW_PTR = 8'h00;
  localparam logic [7:0] REG_COL_PTR = 8'h04;
  localparam logic [7:0] REG_ROW_DEPTH = 8'h08;
  localparam logic [7:0] REG_COL_WIDTH = 8'h0c;
  localparam logic [7:0] REG_BINNING = 8'h10;
  localparam logic [7:0] REG_EXPOSURE = 8'h14;
  localparam logic [7:0] REG_GAIN = 8'h18;
  localparam logic [7:0] REG_CTRL = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_EFFECTIVE = 8'h24;

  // Pixel stream beat
  typedef struct packed {
    logic valid;                                        // Beat present
    logic sof;                                          // First pixel of frame
    logic eol;                                          // Last pixel of a row
    logic [PIX_W-1:0] data;                             // Intensity
  } iwbc_pix_t;

  // Settings handed to the sensor
  typedef struct packed {
    logic [EXP_W-1:0] exposure_us;                      // Integration time
    logic [GAIN_W-1:0] gain_pct;                        // Gain percentage
    logic [1:0] gain_level;                             // Quantised level 0..3
    logic gain_quantised;                               // Level applies instead of percentage
  } iwbc_sensor_cfg_t;

  // Sensor row count of a variant
  function automatic logic [ROW_W-1:0] iwbc_rows(input logic [1:0] v);
    return (v == VAR_MEGA) ? ROWS_MEGA : (v == VAR_WIDE_VGA_VARIANT) ? ROWS_WIDE_VGA_VARIANT : ROWS_FIVE_MP;
  endfunction : iwbc_rows

  // Sensor column count of a variant
  function automatic logic [COL_W-1:0] iwbc_cols(input logic [1:0] v);
    return (v == VAR_MEGA) ? COLS_MEGA : (v == VAR_WIDE_VGA_VARIANT) ? COLS_WIDE_VGA_VARIANT : COLS_FIVE_MP;
  endfunction : iwbc_cols

endpackage : iwbc_pkg

// ===== src/iwbc_top.sv
// Module: image window cropping, 2x2 binning, exposure and gain settings
// Behaviour
// - Row start defaults 0, max rows minus depth
// - Column start defaults 0, max columns minus width
// - Row depth 3 to rows minus start, default full
// - Column width 8 to columns minus start, default full
// - Width rounded down to multiple of 8; readback unrounded
// - Column start rounded down to even; readback unrounded
// - Pixels outside the window output black
// - Binning averages 2x2 groups; default off
// - Binning keeps the sensor frame rate
// - Exposure 50 to 100000 us, default 2500
// - Exposure not writable in auto-trigger mode
// - Gain 0 to 100, default 33 or 0
// - Megapixel gain maps to four 25-point levels
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module iwbc_top
  import iwbc_pkg::*;
#(
  parameter logic [1:0] VARIANT = VAR_FIVE_MP           // Sensor variant fitted
)
(
  input wire logic clk_sys,                             // 200 MHz system clock
  input wire logic srst,                                // Synchronous reset, active high
  input wire logic ce,                                  // Clock enable, freezes all state when low and srst is low
  input wire logic [7:0] reg_addr,                      // Register byte address
  input wire logic [31:0] reg_wdata,                    // Register write data
  input wire logic reg_we,                              // Write strobe
  input wire logic reg_re,                              // Read strobe
  output logic [31:0] reg_rdata,                        // Read data, cycle after read strobe
  input iwbc_pix_t pix_in,                              // Pixel stream from sensor capture
  output iwbc_pix_t pix_out,                            // Windowed, optionally binned stream
  output iwbc_sensor_cfg_t sensor_cfg                   // Exposure and gain to the sensor
);

  // Sensor geometry of this variant
  localparam logic [ROW_W-1:0] ROWS = iwbc_rows(VARIANT);
  localparam logic [COL_W-1:0] COLS = iwbc_cols(VARIANT);
  localparam logic [GAIN_W-1:0] GAIN_RST = (VARIANT == VAR_MEGA) ? GAIN_RST_LO : GAIN_RST_HI;

  // All state of the block except the line buffer
  typedef struct packed {
    logic [ROW_W-1:0] row_ptr;                          // Window row start, as written
    logic [COL_W-1:0] col_ptr;                          // Window column start, as written
    logic [ROW_W-1:0] row_depth;                        // Window rows, as written
    logic [COL_W-1:0] col_width;                        // Window columns, as written
    logic binning;                                      // 2x2 binning enable
    logic [EXP_W-1:0] exposure;                         // Exposure in microseconds
    logic [GAIN_W-1:0] gain;                            // Gain percentage
    logic auto_trig;                                    // Continuous auto-trigger mode
    logic last_reject;                                  // Last register write was refused
    logic [31:0] rdata;                                 // Read data register
    logic [ROW_W-1:0] sh_row_ptr;                       // Frame copy of row start
    logic [ROW_W-1:0] sh_row_depth;                     // Frame copy of row depth
    logic [COL_W-1:0] sh_col_ptr;                       // Frame copy of effective column start
    logic [COL_W-1:0] sh_col_width;                     // Frame copy of effective width
    logic sh_binning;                                   // Frame copy of binning
    logic [ROW_W-1:0] row_cnt;                          // Row of next pixel
    logic [COL_W-1:0] col_cnt;                          // Column of next pixel
    logic [PIX_W-1:0] hold_px;                          // Even-column pixel awaiting its pair
    iwbc_pix_t pix;                                     // Output beat register
  } iwbc_state_t;

  iwbc_state_t state_q;                                 // Registered state
  iwbc_state_t state_d;                                 // Next state
  logic [PIX_W:0] line_buf [LB_DEPTH];                  // Pair sums of the even row
  logic lb_we;                                          // Line buffer write enable
  logic [COL_W-2:0] lb_idx;                             // Line buffer index
  logic [PIX_W:0] lb_wdata;                             // Line buffer write data
  logic [PIX_W:0] lb_rdata;                             // Line buffer read data

  // Quantised gain level, 25 points per level, top level 75..100
  function automatic logic [1:0] gain_level(input logic [GAIN_W-1:0] pct);
    if (pct >= 3 * GAIN_STEP)
    begin
      return 2'h3;
    end
    else if (pct >= 2 * GAIN_STEP)
    begin
      return 2'h2;
    end
    else if (pct >= GAIN_STEP)
    begin
      return 2'h1;
    end
    return 2'h0;
  endfunction : gain_level

  // Column start as applied: cleared low bit
  function automatic logic [COL_W-1:0] eff_col_ptr(input logic [COL_W-1:0] p);
    return {p[COL_W-1:1], 1'b0};
  endfunction : eff_col_ptr

  // Column width as applied: multiple of eight
  function automatic logic [COL_W-1:0] eff_col_width(input logic [COL_W-1:0] w);
    return {w[COL_W-1:3], 3'h0};
  endfunction : eff_col_width

  // Only the pair sums of an even row are kept, so half the widest row is enough
  // Line buffer read is combinational; it is small enough for distributed memory
  assign lb_rdata = line_buf[lb_idx];

  // Line buffer write port
  always_ff @(posedge clk_sys)
  begin
    if (ce && lb_we)
    begin
      line_buf[lb_idx] <= lb_wdata;
    end
  end

  // Next-state logic: register port, window tracking, cropping and binning
  always_comb
  begin
    logic wr_ok;                                        // Current write accepted
    logic [ROW_W-1:0] w_row_ptr;                        // Window in force for this beat
    logic [ROW_W-1:0] w_row_depth;
    logic [COL_W-1:0] w_col_ptr;
    logic [COL_W-1:0] w_col_width;
    logic w_bin;
    logic [ROW_W-1:0] cur_row;                          // Position of this beat
    logic [COL_W-1:0] cur_col;
    logic in_win;                                       // Beat lies inside the window
    logic [PIX_W-1:0] px;                               // Beat after blackening
    logic [PIX_W:0] pair;                               // Horizontal pair sum
    logic [PIX_W+1:0] quad;                             // Sum of a 2x2 group
    wr_ok = 1'b0;
    w_row_ptr = state_q.sh_row_ptr;
    w_row_depth = state_q.sh_row_depth;
    w_col_ptr = state_q.sh_col_ptr;
    w_col_width = state_q.sh_col_width;
    w_bin = state_q.sh_binning;
    cur_row = state_q.row_cnt;
    cur_col = state_q.col_cnt;
    in_win = 1'b0;
    px = '0;
    pair = '0;
    quad = '0;
    lb_we = 1'b0;
    lb_idx = '0;
    lb_wdata = '0;
    state_d = state_q;
    if (srst)
    begin
      // Reset values; the window opens over the whole sensor
      state_d = '0;
      state_d.row_ptr = '0;
      state_d.col_ptr = '0;
      state_d.row_depth = ROWS;
      state_d.col_width = COLS;
      state_d.exposure = EXP_RST_US;
      state_d.gain = GAIN_RST;
      state_d.sh_row_depth = ROWS;
      state_d.sh_col_width = COLS;
    end
    else if (ce)
    begin
      // Register write: window fields are range checked against their partners, exposure and gain against fixed limits
      if (reg_we)
      begin
        case (reg_addr)
          REG_ROW_PTR:
          begin
            // Start must leave room for the stored depth
            wr_ok = reg_wdata <= 32'(ROWS) - 32'(state_q.row_depth);
            if (wr_ok)
            begin
              state_d.row_ptr = reg_wdata[ROW_W-1:0];
            end
          end
          REG_COL_PTR:
          begin
            wr_ok = reg_wdata <= 32'(COLS) - 32'(state_q.col_width);
            if (wr_ok)
            begin
              state_d.col_ptr = reg_wdata[COL_W-1:0];
            end
          end
          REG_ROW_DEPTH:
          begin
            wr_ok = (reg_wdata >= ROW_DEPTH_MIN)
                    && (reg_wdata <= 32'(ROWS) - 32'(state_q.row_ptr));
            if (wr_ok)
            begin
              state_d.row_depth = reg_wdata[ROW_W-1:0];
            end
          end
          REG_COL_WIDTH:
          begin
            wr_ok = (reg_wdata >= COL_WIDTH_MIN)
                    && (reg_wdata <= 32'(COLS) - 32'(state_q.col_ptr));
            if (wr_ok)
            begin
              state_d.col_width = reg_wdata[COL_W-1:0];
            end
          end
          REG_BINNING:
          begin
            wr_ok = 1'b1;
            state_d.binning = reg_wdata[0];
          end
          REG_EXPOSURE:
          begin
            // Locked while the reader triggers itself
            wr_ok = !state_q.auto_trig
                    && (reg_wdata >= EXP_MIN_US) && (reg_wdata <= EXP_MAX_US);
            if (wr_ok)
            begin
              state_d.exposure = reg_wdata[EXP_W-1:0];
            end
          end
          REG_GAIN:
          begin
            wr_ok = reg_wdata <= GAIN_MAX;
            if (wr_ok)
            begin
              state_d.gain = reg_wdata[GAIN_W-1:0];
            end
          end
          REG_CTRL:
          begin
            wr_ok = 1'b1;
            state_d.auto_trig = reg_wdata[0];
          end
          default:
          begin
            // Read-only or unmapped: ignored and flagged
            wr_ok = 1'b0;
          end
        endcase
        state_d.last_reject = !wr_ok;
      end
      // Register read: settings read back exactly as written
      if (reg_re)
      begin
        case (reg_addr)
          REG_ROW_PTR: state_d.rdata = 32'(state_q.row_ptr);
          REG_COL_PTR: state_d.rdata = 32'(state_q.col_ptr);
          REG_ROW_DEPTH: state_d.rdata = 32'(state_q.row_depth);
          REG_COL_WIDTH: state_d.rdata = 32'(state_q.col_width);
          REG_BINNING: state_d.rdata = 32'(state_q.binning);
          REG_EXPOSURE: state_d.rdata = 32'(state_q.exposure);
          REG_GAIN: state_d.rdata = 32'(state_q.gain);
          REG_CTRL: state_d.rdata = 32'(state_q.auto_trig);
          REG_STATUS: state_d.rdata = {27'h0, gain_level(state_q.gain), VARIANT,
                                       state_q.last_reject};
          REG_EFFECTIVE: state_d.rdata = {4'h0, eff_col_width(state_q.col_width), 4'h0,
                                          eff_col_ptr(state_q.col_ptr)};
          default: state_d.rdata = '0;
        endcase
      end
      // Pixel path: one beat in, at most one beat out; input is never stalled
      state_d.pix = '0;
      if (pix_in.valid)
      begin
        // A new frame takes the current settings; mid-frame writes wait for it
        if (pix_in.sof)
        begin
          w_row_ptr = state_q.row_ptr;
          w_row_depth = state_q.row_depth;
          w_col_ptr = eff_col_ptr(state_q.col_ptr);
          w_col_width = eff_col_width(state_q.col_width);
          w_bin = state_q.binning;
          cur_row = '0;
          cur_col = '0;
          state_d.sh_row_ptr = w_row_ptr;
          state_d.sh_row_depth = w_row_depth;
          state_d.sh_col_ptr = w_col_ptr;
          state_d.sh_col_width = w_col_width;
          state_d.sh_binning = w_bin;
        end
        // Window test on the effective rectangle
        in_win = ({1'b0, cur_row} >= {1'b0, w_row_ptr})
                 && ({1'b0, cur_row} < {1'b0, w_row_ptr} + {1'b0, w_row_depth})
                 && ({1'b0, cur_col} >= {1'b0, w_col_ptr})
                 && ({1'b0, cur_col} < {1'b0, w_col_ptr} + {1'b0, w_col_width});
        px = in_win ? pix_in.data : '0;
        // Advance the position counters
        if (pix_in.eol)
        begin
          state_d.row_cnt = ROW_W'(cur_row + 1'b1);
          state_d.col_cnt = '0;
        end
        else
        begin
          state_d.row_cnt = cur_row;
          state_d.col_cnt = COL_W'(cur_col + 1'b1);
        end
        if (!w_bin)
        begin
          // Unbinned: every beat passes
          state_d.pix.valid = 1'b1;
          state_d.pix.sof = pix_in.sof;
          state_d.pix.eol = pix_in.eol;
          state_d.pix.data = px;
        end
        else if (!cur_col[0])
        begin
          // Even column: hold until its pair arrives
          state_d.hold_px = px;
        end
        else
        begin
          // Odd column: even rows store pair sums, odd rows emit the 2x2 average
          pair = {1'b0, state_q.hold_px} + {1'b0, px};
          lb_idx = cur_col[COL_W-1:1];
          if (!cur_row[0])
          begin
            lb_we = 1'b1;
            lb_wdata = pair;
          end
          else
          begin
            quad = {1'b0, lb_rdata} + {1'b0, pair};
            state_d.pix.valid = 1'b1;
            state_d.pix.sof = (cur_row == ROW_W'(1)) && (cur_col == COL_W'(1));
            state_d.pix.eol = pix_in.eol;
            state_d.pix.data = quad[PIX_W+1:2];
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    state_q <= state_d;
  end

  // The level decode is shown on every variant; only the megapixel sensor
  // is told to apply it, the others take the percentage unchanged
  // Outputs straight from flip-flops, except the decoded gain level and the constant quantise flag
  assign reg_rdata = state_q.rdata;
  assign pix_out = state_q.pix;
  assign sensor_cfg.exposure_us = state_q.exposure;
  assign sensor_cfg.gain_pct = state_q.gain;
  assign sensor_cfg.gain_level = gain_level(state_q.gain);
  assign sensor_cfg.gain_quantised = (VARIANT == VAR_MEGA);

endmodule : iwbc_top

// ===== sim/iwbc_props.sv
// Checker: concurrent properties on the ports of the window and binning block
`timescale 1ns/100ps
module iwbc_props
  import iwbc_pkg::*;
#(
  parameter logic [1:0] VARIANT = VAR_FIVE_MP
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  input iwbc_pix_t pix_in,
  input iwbc_pix_t pix_out,
  input iwbc_sensor_cfg_t sensor_cfg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic auto_q; // Shadow of the auto-trigger mode bit
  logic bin_q; // Shadow of the binning bit
  logic bin_act_q; // Binning in force for the running frame
  logic bin_now; // Binning that applies to the current input beat
  // A new binning setting takes hold only at a frame start
  assign bin_now = pix_in.sof ? bin_q : bin_act_q;
  // Track the mode bits as software writes them
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      auto_q <= 1'b0;
      bin_q <= 1'b0;
      bin_act_q <= 1'b0;
    end
    else if (ce)
    begin
      if (reg_we && reg_addr == REG_CTRL)
        auto_q <= reg_wdata[0];
      if (reg_we && reg_addr == REG_BINNING)
        bin_q <= reg_wdata[0];
      if (pix_in.valid && pix_in.sof)
        bin_act_q <= bin_q;
    end
  end
  property p_rst_cfg;
    $fell(srst) |-> sensor_cfg.exposure_us == EXP_RST_US &&
      sensor_cfg.gain_pct == ((VARIANT == VAR_MEGA) ? GAIN_RST_LO : GAIN_RST_HI);
  endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("sensor settings wrong after reset");
  property p_exp_write;
    ce && reg_we && reg_addr == REG_EXPOSURE && !auto_q && reg_wdata >= EXP_MIN_US &&
      reg_wdata <= EXP_MAX_US |=> sensor_cfg.exposure_us == $past(reg_wdata[EXP_W-1:0]);
  endproperty
  a_exp_write: assert property (p_exp_write)
    else $error("legal exposure write not applied");
  property p_exp_lock;
    ce && reg_we && reg_addr == REG_EXPOSURE && auto_q |=> $stable(sensor_cfg.exposure_us);
  endproperty
  a_exp_lock: assert property (p_exp_lock)
    else $error("exposure changed in auto-trigger mode");
  property p_exp_range;
    sensor_cfg.exposure_us >= EXP_MIN_US && sensor_cfg.exposure_us <= EXP_MAX_US;
  endproperty
  a_exp_range: assert property (p_exp_range)
    else $error("exposure outside its range");
  property p_gain_range;
    sensor_cfg.gain_pct <= GAIN_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range)
    else $error("gain above its range");
  property p_gain_level;
    sensor_cfg.gain_level == ((sensor_cfg.gain_pct >= 7'h4b) ? 2'h3 :
      2'(sensor_cfg.gain_pct / GAIN_STEP));
  endproperty
  a_gain_level: assert property (p_gain_level)
    else $error("gain level does not match gain");
  property p_gain_quant;
    sensor_cfg.gain_quantised == (VARIANT == VAR_MEGA);
  endproperty
  a_gain_quant: assert property (p_gain_quant)
    else $error("gain quantisation flag wrong");
  property p_beat_cause;
    pix_out.valid |-> $past(pix_in.valid) && $past(ce);
  endproperty
  a_beat_cause: assert property (p_beat_cause)
    else $error("output beat without input beat");
  property p_unbinned;
    ce && pix_in.valid && !bin_now |=> pix_out.valid && pix_out.sof == $past(pix_in.sof) &&
      pix_out.eol == $past(pix_in.eol);
  endproperty
  a_unbinned: assert property (p_unbinned)
    else $error("unbinned beat not passed on");
  property p_binned_first;
    ce && pix_in.valid && pix_in.sof && bin_now |=> !pix_out.valid;
  endproperty
  a_binned_first: assert property (p_binned_first)
    else $error("binned output on first pixel");
  property p_ce_hold;
    !ce |=> $stable(reg_rdata) && $stable(pix_out) && $stable(sensor_cfg);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("outputs moved while clock enable low");
endmodule : iwbc_props
bind iwbc_top iwbc_props #(.VARIANT(VARIANT)) iwbc_props_i (.clk_sys(clk_sys), .srst(srst),
  .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .pix_in(pix_in), .pix_out(pix_out), .sensor_cfg(sensor_cfg));

// ===== sim/iwbc_sensor_model.sv
// Sensor model: emits short frames of a known pixel pattern, optionally with idle gaps
`timescale 1ns/100ps
module iwbc_sensor_model
  import iwbc_pkg::*;
#(
  parameter int ROWS = 6,
  parameter int COLS = 24
)
(
  input wire logic clk_sys,
  input wire logic start,
  input wire logic [3:0] gap,
  output iwbc_pix_t pix,
  output logic busy
);
  int r = 0; // Row of the next beat
  int c = 0; // Column of the next beat
  int w = 0; // Idle cycles spent before the next beat
  initial pix = '0;
  initial busy = 1'b0;
  // Idle data flips each cycle so that nothing stale looks valid
  always @(posedge clk_sys)
  begin
    if (start)
    begin
      busy <= 1'b1;
      r = 0;
      c = 0;
      w = 0;
      pix <= {3'h0, ~pix.data};
    end
    else if (busy && w >= gap)
    begin
      w = 0;
      pix <= {1'b1, r == 0 && c == 0, c == COLS - 1, 8'((r * 32 + c + 1) % 256)};
      c++;
      if (c == COLS)
      begin
        c = 0;
        r++;
      end
      if (r == ROWS)
        busy <= 1'b0;
    end
    else
    begin
      w++;
      pix <= {3'h0, ~pix.data};
    end
  end
endmodule : iwbc_sensor_model

// ===== sim/tb_iwbc_top.sv
// Testbench: registers, window cropping, binning, exposure and gain of the block
`timescale 1ns/100ps
module tb_iwbc_top
  import iwbc_pkg::*;
();
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  iwbc_pix_t pix_in;
  iwbc_pix_t pix_out;
  iwbc_sensor_cfg_t sensor_cfg;
  logic sm_start = 1'b0; // Frame request to the sensor model
  logic [3:0] sm_gap = 4'h0; // Idle cycles between sensor beats
  logic sm_busy;
  int mismatches = 0;
  int cmp_count = 0;
  int w_r0 = 0, w_r1 = 6, w_c0 = 0, w_c1 = 24; // Window the bench expects
  logic binm = 1'b0; // Bench expects binned output
  int orow = 0, ocol = 0, nbeat = 0; // Output position and beat count
  int exp_v[4] = '{32'h31, 32'h32, 32'h186a0, 32'h186a1};
  logic exp_r[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  int gv[8] = '{32'h0, 32'h18, 32'h19, 32'h31, 32'h32, 32'h4a, 32'h4b, 32'h64};
  always #2.5 clk_sys = ~clk_sys;
  iwbc_top #(.VARIANT(VAR_WIDE_VGA_VARIANT)) iwbc_top_i (.clk_sys(clk_sys), .srst(srst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .pix_in(pix_in), .pix_out(pix_out), .sensor_cfg(sensor_cfg));
  iwbc_sensor_model iwbc_sensor_model_i (.clk_sys(clk_sys), .start(sm_start), .gap(sm_gap),
    .pix(pix_in), .busy(sm_busy));
  // Sensor pixel as cropped by the expected window
  function automatic int blk(int r, int c);
    if (r >= w_r0 && r < w_r1 && c >= w_c0 && c < w_c1)
      return (r * 32 + c + 1) % 256;
    return 0;
  endfunction : blk
  task automatic results();
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    @(posedge clk_sys);
    chk(reg_rdata, e);
  endtask : rc
  // Write, then read the refusal flag back from status
  task automatic wst(input logic [7:0] a, input logic [31:0] d, input logic rej);
    logic [31:0] s;
    wr(a, d);
    @(posedge clk_sys);
    reg_addr <= REG_STATUS;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    @(posedge clk_sys);
    s = reg_rdata;
    chk({31'h0, s[0]}, {31'h0, rej});
  endtask : wst
  // Run one sensor frame under a bounded wait and count output beats
  task automatic frame(input logic b, input logic [3:0] g, input int n);
    int i;
    binm = b;
    @(posedge clk_sys);
    sm_gap <= g;
    sm_start <= 1'b1;
    @(posedge clk_sys);
    sm_start <= 1'b0;
    for (i = 0; i < 3000 && (sm_busy || i < 2); i++)
      @(posedge clk_sys);
    if (sm_busy)
    begin
      mismatches++;
      results();
    end
    repeat (3) @(posedge clk_sys);
    chk(nbeat, n);
  endtask : frame
  // Compare every output beat with the cropped, optionally averaged pattern
  always @(posedge clk_sys)
  begin
    if (pix_out.valid)
    begin
      if (pix_out.sof)
      begin
        orow = 0;
        ocol = 0;
        nbeat = 0;
      end
      if (binm)
        chk(pix_out.data, (blk(2 * orow, 2 * ocol) + blk(2 * orow, 2 * ocol + 1) +
          blk(2 * orow + 1, 2 * ocol) + blk(2 * orow + 1, 2 * ocol + 1)) / 4);
      else
        chk(pix_out.data, blk(orow, ocol));
      chk(pix_out.eol, ocol == (binm ? 11 : 23));
      nbeat++;
      if (pix_out.eol)
      begin
        orow++;
        ocol = 0;
      end
      else
        ocol++;
    end
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rc(REG_ROW_PTR, 32'h0);
    rc(REG_COL_PTR, 32'h0);
    rc(REG_ROW_DEPTH, 32'h1e0);
    rc(REG_COL_WIDTH, 32'h2f0);
    rc(REG_BINNING, 32'h0);
    rc(REG_EXPOSURE, 32'h9c4);
    rc(REG_GAIN, 32'h21);
    rc(REG_STATUS, 32'hc);
    frame(1'b0, 4'h0, 32'h90);
    wst(REG_ROW_PTR, 32'h1, 1'b1);
    wst(REG_ROW_DEPTH, 32'h2, 1'b1);
    wst(REG_ROW_DEPTH, 32'h3, 1'b0);
    wst(REG_ROW_PTR, 32'h1dd, 1'b0);
    wst(REG_ROW_DEPTH, 32'h4, 1'b1);
    wst(REG_ROW_PTR, 32'h2, 1'b0);
    wst(REG_COL_WIDTH, 32'h7, 1'b1);
    wst(REG_COL_WIDTH, 32'hd, 1'b0);
    wst(REG_COL_PTR, 32'h2e4, 1'b1);
    wst(REG_COL_PTR, 32'h2e3, 1'b0);
    wst(REG_COL_PTR, 32'h5, 1'b0);
    rc(REG_COL_WIDTH, 32'hd);
    rc(REG_COL_PTR, 32'h5);
    rc(REG_EFFECTIVE, 32'h00080004);
    wst(REG_STATUS, 32'h0, 1'b1);
    wst(8'h30, 32'h1, 1'b1);
    rc(8'h30, 32'h0);
    w_r0 = 2;
    w_r1 = 5;
    w_c0 = 4;
    w_c1 = 12;
    frame(1'b0, 4'h0, 32'h90);
    wst(REG_BINNING, 32'h1, 1'b0);
    frame(1'b1, 4'h0, 32'h24);
    frame(1'b1, 4'h2, 32'h24);
    wst(REG_BINNING, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++)
      wst(REG_EXPOSURE, exp_v[i], exp_r[i]);
    rc(REG_EXPOSURE, 32'h186a0);
    wst(REG_CTRL, 32'h1, 1'b0);
    wst(REG_EXPOSURE, 32'h3e8, 1'b1);
    rc(REG_EXPOSURE, 32'h186a0);
    chk(sensor_cfg.exposure_us, 32'h186a0);
    wst(REG_CTRL, 32'h0, 1'b0);
    wst(REG_EXPOSURE, 32'h3e8, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      wst(REG_GAIN, gv[i], 1'b0);
      chk(sensor_cfg.gain_level, ((gv[i] > 75) ? 75 : gv[i]) / 25);
    end
    wst(REG_GAIN, 32'h65, 1'b1);
    chk(sensor_cfg.gain_pct, 32'h64);
    chk(sensor_cfg.gain_quantised, 32'h0);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rc(REG_GAIN, 32'h21);
    chk(sensor_cfg.exposure_us, 32'h9c4);
    ce <= 1'b0;
    wr(REG_GAIN, 32'h10);
    ce <= 1'b1;
    rc(REG_GAIN, 32'h21);
    results();
  end
endmodule : tb_iwbc_top
